/* File: design/coc_ctrl.sv */
// Decided for this implementation: the APB interface to the registers and the register addresses.
module coc_ctrl
   import coc_pkg::*;
#(
   parameter int CNT_W = 6
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event and shutdown sources, asynchronous
   input wire logic [NUM_RISE_SRC-1:0] rise_src_in,
   input wire logic fall_event_in,
   input wire logic shutdown_in,
   // output pins
   output logic output_a_out,
   output logic output_a_oe_n,
   output logic output_b_out,
   output logic output_b_oe_n,
   // clock source and delay chain control
   output logic [1:0] gen_clock_select,
   output logic fast_osc_keep_on,
   output logic rise_chain_select,
   output logic fall_chain_select,
   // working count buffers
   output logic [31:0] dbk_buf,
   output logic [15:0] phase_buf
);

   if (CNT_W < 1 || CNT_W > 8) begin : g_cnt_w_check
      $error("CNT_W must be 1..8");
   end

   logic [7:0] ctrl_a_r;
   logic [7:0] ctrl_b_r;
   logic [7:0] rise_sel_r;
   logic [7:0] shdn_r;
   logic [31:0] dbk_r;
   logic [15:0] phase_r;
   logic [31:0] dbk_buf_r;
   logic [15:0] phase_buf_r;
   logic ack_r;
   logic [31:0] prdata_r;
   logic [NUM_RISE_SRC+1:0] sync1_r;
   logic [NUM_RISE_SRC+1:0] sync2_r;
   logic rise_lvl_r;
   logic fall_lvl_r;
   logic hold_r;
   logic pp_sel_r;
   coc_state_t state_r;
   coc_state_t state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;

   // bus decode
   wire access = psel && penable;
   wire wr_en = access && pready && pwrite;
   wire hit_a = (paddr == ADDR_CTRL_A);
   wire hit_b = (paddr == ADDR_CTRL_B);
   wire hit_rise = (paddr == ADDR_RISE_SRC);
   wire hit_shdn = (paddr == ADDR_SHDN);
   wire hit_dbk = (paddr == ADDR_DB_BK);
   wire hit_phase = (paddr == ADDR_PHASE);
   wire hit_stat = (paddr == ADDR_STATUS);
   wire mapped = hit_a | hit_b | hit_rise | hit_shdn | hit_dbk | hit_phase | hit_stat;

   // one wait state for flopped read data; a frozen slave never answers
   assign pready = access && ack_r && clk_en;
   assign pslverr = pready && !mapped;
   assign prdata = prdata_r;

   // control fields
   wire gen_en = ctrl_a_r[EN_BIT];
   wire load_req = ctrl_a_r[LD_BIT];
   wire push_pull = ctrl_a_r[MD_BIT];
   wire shdn_act = shdn_r[SD_ACT_BIT];
   wire auto_rst = shdn_r[ARS_BIT];
   coc_ovr_t ovr_a;
   coc_ovr_t ovr_b;
   assign ovr_a = coc_ovr_t'(shdn_r[OVA_LSB +: 2]);
   assign ovr_b = coc_ovr_t'(shdn_r[OVB_LSB +: 2]);

   // synchronised sources
   wire [NUM_RISE_SRC-1:0] rise_src_s = sync2_r[NUM_RISE_SRC-1:0];
   wire fall_s = sync2_r[NUM_RISE_SRC];
   wire shdn_in_s = sync2_r[NUM_RISE_SRC+1];
   wire rise_lvl = |(rise_src_s & rise_sel_r[NUM_RISE_SRC-1:0]);
   wire rise_evt = gen_en && rise_lvl && !rise_lvl_r;
   wire fall_evt = gen_en && fall_s && !fall_lvl_r;

   // shutdown: sticky bit, hardware set wins over software clear
   wire shdn_state = shdn_act || shdn_in_s;
   wire sw_wr_shdn = wr_en && hit_shdn;
   wire [7:0] shdn_wdata = pwdata[7:0] & SHDN_MASK;
   logic [7:0] shdn_nxt;
   always_comb begin
      shdn_nxt = sw_wr_shdn ? shdn_wdata : shdn_r;
      if (shdn_in_s) begin
         shdn_nxt[SD_ACT_BIT] = 1'b1;
      end else if (shdn_nxt[ARS_BIT] && gen_en) begin
         shdn_nxt[SD_ACT_BIT] = 1'b0;
      end
   end

   // load request: hardware clear only when a transfer happens, a new set wins
   wire sw_wr_a = wr_en && hit_a;
   wire load_xfer = load_req && rise_evt;
   wire sw_set_ld = sw_wr_a && pwdata[LD_BIT];
   logic [7:0] ctrl_a_nxt;
   always_comb begin
      ctrl_a_nxt = sw_wr_a ? (pwdata[7:0] & CTRL_A_MASK) : ctrl_a_r;
      if (load_xfer && !sw_set_ld) begin
         ctrl_a_nxt[LD_BIT] = 1'b0;
      end
   end

   // dead band targets, zero when the analog chain does the timing
   assign rise_chain_select = ctrl_b_r[RDBTS_BIT];
   assign fall_chain_select = ctrl_b_r[FDBTS_BIT];
   wire [CNT_W-1:0] rise_db = rise_chain_select ? '0 : dbk_buf_r[CNT_W-1:0];
   wire [CNT_W-1:0] fall_db = fall_chain_select ? '0 : dbk_buf_r[FDB_LSB +: CNT_W];

   // waveform sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         ST_OFF: begin
            if (rise_evt) begin
               state_nxt = ST_DB_RISE;
               cnt_nxt = rise_db;
            end
         end
         ST_DB_RISE: begin
            if (fall_evt) begin
               state_nxt = ST_DB_FALL;
               cnt_nxt = fall_db;
            end else if (cnt_r == '0) begin
               state_nxt = ST_ON;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
         ST_ON: begin
            if (fall_evt) begin
               state_nxt = ST_DB_FALL;
               cnt_nxt = fall_db;
            end
         end
         ST_DB_FALL: begin
            if (rise_evt) begin
               state_nxt = ST_DB_RISE;
               cnt_nxt = rise_db;
            end else if (cnt_r == '0) begin
               state_nxt = ST_OFF;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
         end
      endcase
      if (!gen_en) begin
         state_nxt = ST_OFF;
         cnt_nxt = '0;
      end
   end

   // raw active levels before polarity
   wire sync_a = (state_r == ST_ON);
   wire sync_b = (state_r == ST_OFF);
   wire pwm_high = (state_r == ST_ON) || (state_r == ST_DB_RISE);
   wire raw_a = push_pull ? (pwm_high && !pp_sel_r) : sync_a;
   wire raw_b = push_pull ? (pwm_high && pp_sel_r) : sync_b;
   wire inact_a = 1'b0;
   wire inact_b = !push_pull;
   wire inv_a = ctrl_a_r[INVA_BIT];
   wire inv_b = ctrl_a_r[INVB_BIT];

   // override applies during shutdown and until the next rising event
   wire overriding = shdn_state || hold_r;
   logic lvl_a;
   logic lvl_b;
   logic tri_a;
   logic tri_b;
   always_comb begin
      lvl_a = raw_a ^ inv_a;
      lvl_b = raw_b ^ inv_b;
      tri_a = 1'b0;
      tri_b = 1'b0;
      if (overriding) begin
         unique case (ovr_a)
            OVR_LOW: lvl_a = 1'b0;
            OVR_HIGH: lvl_a = 1'b1;
            OVR_TRI: tri_a = 1'b1;
            OVR_INACTIVE: lvl_a = inact_a ^ inv_a;
         endcase
         unique case (ovr_b)
            OVR_LOW: lvl_b = 1'b0;
            OVR_HIGH: lvl_b = 1'b1;
            OVR_TRI: tri_b = 1'b1;
            OVR_INACTIVE: lvl_b = inact_b ^ inv_b;
         endcase
      end
   end

   // pin drive, registered
   wire drive_a = gen_en && ctrl_a_r[OEA_BIT] && !tri_a;
   wire drive_b = gen_en && ctrl_a_r[OEB_BIT] && !tri_b;

   // clock source steering
   assign gen_clock_select = ctrl_b_r[CS_LSB +: 2];
   assign fast_osc_keep_on = gen_en && (coc_clk_t'(gen_clock_select) == CLK_FAST_OSC);
   assign dbk_buf = dbk_buf_r;
   assign phase_buf = phase_buf_r;

   // read mux
   wire [7:0] status = {3'b000, pp_sel_r, output_b_out, output_a_out, hold_r, shdn_state};
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = WORD_RST;
      if (hit_a) rd_mux[7:0] = ctrl_a_r & CTRL_A_MASK;
      if (hit_b) rd_mux[7:0] = ctrl_b_r & CTRL_B_MASK;
      if (hit_rise) rd_mux[7:0] = rise_sel_r & RISE_MASK;
      if (hit_shdn) rd_mux[7:0] = shdn_r & SHDN_MASK;
      if (hit_dbk) rd_mux = dbk_r;
      if (hit_phase) rd_mux[15:0] = phase_r;
      if (hit_stat) rd_mux[7:0] = status;
   end

   // apb handshake and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_r <= 1'b0;
         prdata_r <= WORD_RST;
      end else if (clk_en) begin
         ack_r <= access && !ack_r;
         if (access && !ack_r) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_a_r <= REG_RST;
         ctrl_b_r <= REG_RST;
         rise_sel_r <= REG_RST;
         shdn_r <= REG_RST;
         dbk_r <= WORD_RST;
         phase_r <= WORD_RST[15:0];
      end else if (clk_en) begin
         ctrl_a_r <= ctrl_a_nxt;
         shdn_r <= shdn_nxt;
         if (wr_en && hit_b) ctrl_b_r <= pwdata[7:0] & CTRL_B_MASK;
         if (wr_en && hit_rise) rise_sel_r <= pwdata[7:0] & RISE_MASK;
         if (wr_en && hit_dbk) dbk_r <= pwdata;
         if (wr_en && hit_phase) phase_r <= pwdata[15:0];
      end
   end

   // working buffers: direct while disabled, on request while running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbk_buf_r <= WORD_RST;
         phase_buf_r <= WORD_RST[15:0];
      end else if (clk_en) begin
         if (!gen_en) begin
            dbk_buf_r <= dbk_r;
            phase_buf_r <= phase_r;
         end else if (load_xfer) begin
            dbk_buf_r <= dbk_r;
            phase_buf_r <= phase_r;
         end
      end
   end

   // two-flop synchronisers for asynchronous sources
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else if (clk_en) begin
         sync1_r <= {shutdown_in, fall_event_in, rise_src_in};
         sync2_r <= sync1_r;
      end
   end

   // sequencer, edge history, start-up hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_OFF;
         cnt_r <= '0;
         rise_lvl_r <= 1'b0;
         fall_lvl_r <= 1'b0;
         hold_r <= 1'b1;
         pp_sel_r <= 1'b0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         rise_lvl_r <= rise_lvl;
         fall_lvl_r <= fall_s;
         if (!gen_en || shdn_state) begin
            hold_r <= 1'b1;
         end else if (rise_evt) begin
            hold_r <= 1'b0;
         end
         if (!gen_en) begin
            pp_sel_r <= 1'b0;
         end else if (rise_evt && state_r != ST_ON) begin
            pp_sel_r <= !pp_sel_r;
         end
      end
   end

   // registered pin levels; reset leaves pins undriven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_a_out <= 1'b0;
         output_b_out <= 1'b0;
         output_a_oe_n <= 1'b1;
         output_b_oe_n <= 1'b1;
      end else if (clk_en) begin
         output_a_out <= lvl_a;
         output_b_out <= lvl_b;
         output_a_oe_n <= !drive_a;
         output_b_oe_n <= !drive_b;
      end
   end

endmodule : coc_ctrl

/* File: shared/coc_pkg.sv */
package coc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A = 8'h00;
   localparam logic [7:0] ADDR_CTRL_B = 8'h04;
   localparam logic [7:0] ADDR_RISE_SRC = 8'h08;
   localparam logic [7:0] ADDR_SHDN = 8'h0C;
   localparam logic [7:0] ADDR_DB_BK = 8'h10;
   localparam logic [7:0] ADDR_PHASE = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // generator_control_a fields
   localparam int EN_BIT = 7;
   localparam int OEB_BIT = 6;
   localparam int OEA_BIT = 5;
   localparam int INVB_BIT = 4;
   localparam int INVA_BIT = 3;
   localparam int LD_BIT = 2;
   localparam int MD_BIT = 0;
   // fall dead band count position inside the count word
   localparam int FDB_LSB = 8;
   // generator_control_b fields
   localparam int RDBTS_BIT = 7;
   localparam int FDBTS_BIT = 6;
   localparam int CS_LSB = 0;
   // shutdown_control fields
   localparam int SD_ACT_BIT = 7;
   localparam int ARS_BIT = 6;
   localparam int OVB_LSB = 2;
   localparam int OVA_LSB = 0;
   // status fields
   localparam int ST_SHDN_BIT = 0;
   localparam int ST_HOLD_BIT = 1;
   localparam int ST_OUTA_BIT = 2;
   localparam int ST_OUTB_BIT = 3;
   localparam int ST_PPSEL_BIT = 4;
   // implemented-bit masks, others read zero
   localparam logic [7:0] CTRL_A_MASK = 8'hFD;
   localparam logic [7:0] CTRL_B_MASK = 8'hC3;
   localparam logic [7:0] RISE_MASK = 8'h7F;
   localparam logic [7:0] SHDN_MASK = 8'hCF;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam int NUM_RISE_SRC = 7;
   typedef enum logic [1:0] {
      OVR_LOW = 2'b00,
      OVR_HIGH = 2'b01,
      OVR_TRI = 2'b10,
      OVR_INACTIVE = 2'b11
   } coc_ovr_t;
   typedef enum logic [1:0] {
      CLK_SYS = 2'b00,
      CLK_SYS_DIV4 = 2'b01,
      CLK_FAST_OSC = 2'b10,
      CLK_RESERVED = 2'b11
   } coc_clk_t;
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_DB_RISE = 2'b01,
      ST_ON = 2'b10,
      ST_DB_FALL = 2'b11
   } coc_state_t;
endpackage : coc_pkg

/* File: test/coc_ctrl_assertions.sv */
module coc_ctrl_assertions
   import coc_pkg::*;
(
   // clock, reset, apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and selects
   input wire logic output_a_oe_n,
   input wire logic output_b_oe_n,
   input wire logic [1:0] gen_clock_select,
   input wire logic fast_osc_keep_on,
   input wire logic rise_chain_select,
   input wire logic fall_chain_select,
   input wire logic [31:0] dbk_buf,
   input wire logic [15:0] phase_buf
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic xfer = psel && penable && pready;
   wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= ADDR_STATUS);
   wire logic [3:0] sel_b = {rise_chain_select, fall_chain_select, gen_clock_select};
   wire logic [3:0] wsel = {pwdata[7:6], pwdata[1:0]};
   a_ready_wait: assert property ((psel && !penable && clk_en) ##1 (penable && clk_en)
      |-> !pready ##1 (pready || !clk_en)) else $error("pready not after one wait");
   a_err_unmapped: assert property (xfer |-> pslverr == !mapped)
      else $error("pslverr wrong");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_keep_on: assert property (fast_osc_keep_on |-> gen_clock_select == 2'h2)
      else $error("keep on without fast clock");
   a_select_hold: assert property (!(xfer && pwrite) |=> $stable(sel_b))
      else $error("select changed without write");
   a_ctrlb_write: assert property (xfer && pwrite && paddr == ADDR_CTRL_B
      |=> sel_b == $past(wsel))
      else $error("control b write lost");
   a_ctrlb_read: assert property (xfer && !pwrite && paddr == ADDR_CTRL_B
      |-> prdata == {24'h0, sel_b[3:2], 4'h0, sel_b[1:0]}) else $error("control b read");
   a_reset_vals: assert property ($rose(presetn) |-> output_a_oe_n && output_b_oe_n
      && dbk_buf == 32'h0 && phase_buf == 16'h0 && sel_b == 4'h0 && !fast_osc_keep_on)
      else $error("reset state wrong");
endmodule : coc_ctrl_assertions

bind coc_ctrl coc_ctrl_assertions i_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .output_a_oe_n, .output_b_oe_n,
   .gen_clock_select, .fast_osc_keep_on, .rise_chain_select, .fall_chain_select, .dbk_buf,
   .phase_buf);

/* File: test/coc_switch_model.sv */
module coc_switch_model (
   // generator pins
   input wire logic out_a,
   input wire logic oe_a_n,
   input wire logic out_b,
   input wire logic oe_b_n,
   // gate levels at the switches
   output logic gate_a,
   output logic gate_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // gate pull-down keeps a released switch off
   // pins used as plain digital drive, analog input path kept off
   assign gate_a = oe_a_n ? 1'b0 : out_a;
   assign gate_b = oe_b_n ? 1'b0 : out_b;
endmodule : coc_switch_model

/* File: test/test_complementary_output_control.sv */
module test_complementary_output_control
   import coc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [6:0] src = 7'h00;
   logic fall_in = 1'b0;
   logic sd_in = 1'b0;
   logic clk_en = 1'b1;
   logic rcs, fcs;
   logic [31:0] prdata, q;
   logic pready, pslverr, last_err, oa, ob, oea_n, oeb_n, keep, gate_a, gate_b;
   logic [1:0] csel;
   logic [31:0] dbk_buf;
   logic [15:0] phase_buf;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   coc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rise_src_in(src), .fall_event_in(fall_in),
      .shutdown_in(sd_in), .output_a_out(oa), .output_a_oe_n(oea_n), .output_b_out(ob),
      .output_b_oe_n(oeb_n), .gen_clock_select(csel), .fast_osc_keep_on(keep),
      .rise_chain_select(rcs), .fall_chain_select(fcs), .dbk_buf(dbk_buf),
      .phase_buf(phase_buf));
   coc_switch_model i_sw (.out_a(oa), .oe_a_n(oea_n), .out_b(ob), .oe_b_n(oeb_n),
      .gate_a(gate_a), .gate_b(gate_b));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // request held until the edge that samples pready high; data taken at that edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      check("pready", pready, 1'b1);
      q = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so register-driven outputs have settled when callers look
      @(posedge pclk);
   endtask : apb
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, q, exp);
   endtask : rd
   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask : ticks
   task automatic pulse(input int k);
      @(posedge pclk);
      src <= 7'h01 << k;
      ticks(4);
      src <= 7'h00;
      ticks(4);
   endtask : pulse
   task automatic fall();
      @(posedge pclk);
      fall_in <= 1'b1;
      ticks(4);
      fall_in <= 1'b0;
      ticks(4);
   endtask : fall
   task automatic wait_a(input logic v);
      int n;
      n = 0;
      while (gate_a !== v && n < 40) begin
         @(negedge pclk);
         n++;
      end
      check("gate_a", gate_a, v);
   endtask : wait_a
   task automatic t_regs();
      rd("ctrl_a", ADDR_CTRL_A, 32'h0);
      rd("ctrl_b", ADDR_CTRL_B, 32'h0);
      rd("rise_sel", ADDR_RISE_SRC, 32'h0);
      apb(1'b1, ADDR_CTRL_A, 32'hFFFF_FF7B);
      rd("ctrl_a", ADDR_CTRL_A, 32'h79);
      apb(1'b1, ADDR_RISE_SRC, 32'hFFFF_FFFF);
      rd("rise_sel", ADDR_RISE_SRC, 32'h7F);
      for (int c = 0; c < 4; c++) begin
         apb(1'b1, ADDR_CTRL_B, 32'hFC | c);
         rd("ctrl_b", ADDR_CTRL_B, 32'hC0 | c);
         check("clock_sel", csel, c);
         check("chain_sel", {rcs, fcs}, 2'b11);
         check("keep_on", keep, 1'b0);
      end
      apb(1'b0, 8'h1C, 32'h0);
      check("err", last_err, 1'b1);
      apb(1'b1, ADDR_CTRL_A, 32'h0);
   endtask : t_regs
   task automatic t_start();
      apb(1'b1, ADDR_DB_BK, 32'h4433_2211);
      ticks(1);
      check("dbk_buf", dbk_buf, 32'h4433_2211);
      apb(1'b1, ADDR_PHASE, 32'h5566);
      ticks(1);
      check("phase_buf", phase_buf, 16'h5566);
      // overrides chosen opposite to the idle waveform so the hold is visible
      apb(1'b1, ADDR_SHDN, 32'h81);
      apb(1'b1, ADDR_RISE_SRC, 32'h01);
      apb(1'b1, ADDR_CTRL_B, 32'h02);
      check("chain_sel", {rcs, fcs}, 2'b00);
      apb(1'b1, ADDR_CTRL_A, 32'hE0);
      check("keep_on", keep, 1'b1);
      ticks(4);
      check("gate_a", gate_a, 1'b1);
      check("gate_b", gate_b, 1'b0);
      apb(1'b1, ADDR_SHDN, 32'h01);
      pulse(1);
      check("gate_a", gate_a, 1'b1);
      pulse(0);
      check("gate_a", gate_a, 1'b0);
      wait_a(1'b1);
      check("gate_b", gate_b, 1'b0);
   endtask : t_start
   task automatic t_load();
      apb(1'b1, ADDR_DB_BK, 32'h0A0B_0C0D);
      ticks(2);
      check("dbk_buf", dbk_buf, 32'h4433_2211);
      apb(1'b1, ADDR_CTRL_A, 32'hE4);
      rd("ctrl_a", ADDR_CTRL_A, 32'hE4);
      pulse(0);
      check("dbk_buf", dbk_buf, 32'h0A0B_0C0D);
      rd("ctrl_a", ADDR_CTRL_A, 32'hE0);
   endtask : t_load
   task automatic t_sources();
      for (int k = 0; k < 7; k++) begin
         apb(1'b1, ADDR_RISE_SRC, 32'h01 << k);
         fall();
         wait_a(1'b0);
         pulse((k + 1) % 7);
         check("gate_a", gate_a, 1'b0);
         pulse(k);
         wait_a(1'b1);
      end
   endtask : t_sources
   task automatic t_pins();
      fall();
      wait_a(1'b0);
      apb(1'b1, ADDR_CTRL_A, 32'hE8);
      ticks(4);
      check("gate_a", gate_a, 1'b1);
      apb(1'b1, ADDR_CTRL_A, 32'hC8);
      ticks(4);
      check("oe_a_n", oea_n, 1'b1);
      apb(1'b1, ADDR_CTRL_A, 32'hE0);
   endtask : t_pins
   task automatic t_shutdown();
      apb(1'b1, ADDR_SHDN, 32'h08);
      @(posedge pclk);
      sd_in <= 1'b1;
      ticks(6);
      rd("shdn", ADDR_SHDN, 32'h88);
      check("oe_b_n", oeb_n, 1'b1);
      apb(1'b1, ADDR_SHDN, 32'h48);
      sd_in <= 1'b0;
      ticks(6);
      rd("shdn", ADDR_SHDN, 32'h48);
   endtask : t_shutdown
   task automatic t_disable();
      apb(1'b1, ADDR_SHDN, 32'h84);
      apb(1'b1, ADDR_CTRL_A, 32'h64);
      apb(1'b1, ADDR_SHDN, 32'h04);
      fall();
      pulse(6);
      check("gate_a", gate_a, 1'b0);
      rd("ctrl_a", ADDR_CTRL_A, 32'h64);
   endtask : t_disable
   // a shutdown pulse while frozen must leave no trace
   task automatic t_freeze();
      @(posedge pclk);
      clk_en <= 1'b0;
      sd_in <= 1'b1;
      ticks(6);
      sd_in <= 1'b0;
      ticks(4);
      clk_en <= 1'b1;
      ticks(4);
      rd("shdn", ADDR_SHDN, 32'h04);
   endtask : t_freeze
   initial begin
      ticks(16);
      presetn <= 1'b1;
      t_regs();
      t_start();
      t_load();
      t_sources();
      t_pins();
      t_shutdown();
      t_disable();
      t_freeze();
      print_verdict();
   end
endmodule : test_complementary_output_control
